// >>> bench/other_port.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Second controller that shares the drives
// ---------------------------------------------------------------------------
module other_port
#(
  parameter int NDRV = 8
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench wishes and our ownership
  input wire logic [NDRV-1:0] want,
  input wire logic [NDRV-1:0] held,
  // Drive pins
  output logic [NDRV-1:0] other_busy,
  output logic [NDRV-1:0] drive_present
);
  // no neutral grab
  // The far port wins only a drive this port does not hold, and frees it when told.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      other_busy <= '0;
    else
      other_busy <= want & (other_busy | ~held);
  end

  // Every drive is powered before the run starts.
  assign drive_present = '1;
endmodule : other_port

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench
  import seize_pkg::*;
;
  localparam int OS = 40;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, lerr;
  logic [7:0] paddr, want, other_busy, drive_present, held;
  logic [31:0] pwdata, prdata, q;
  logic dual_port_sw, dual_access_sw, xfer_active, cmd_go, irq;
  cmd_s cmd, last_cmd;
  int err_count, n_checks, ngo, b;

  dual_port_seize #(.NDRV(8), .ONE_SEC(OS)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .other_busy(other_busy),
    .drive_present(drive_present), .dual_port_sw(dual_port_sw),
    .dual_access_sw(dual_access_sw), .xfer_active(xfer_active), .held(held),
    .cmd_go(cmd_go), .cmd(cmd), .irq(irq));

  other_port #(.NDRV(8)) peer_u (.clk(clk), .nrst(nrst), .want(want), .held(held),
    .other_busy(other_busy), .drive_present(drive_present));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      chk(32'h0, 32'h1);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // Free-running 20 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Commands are counted as they leave; a check compares against a taken base.
  always @(posedge clk)
  begin
    if (cmd_go === 1'b1)
    begin
      ngo++;
      last_cmd = cmd;
    end
  end

  // A hang is cut off well past the expected run of about a thousand cycles.
  initial
  begin
    #1000000;
    err_count++;
    results();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {want, dual_port_sw, dual_access_sw, xfer_active} = '0;
    {err_count, n_checks, ngo} = '0;
    cyc(12);
    nrst <= 1'b1;
    // Single-port mode: a fresh drive is blind for one interval.
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_DATA, 32'h1111);
    rd(ADDR_DATA);
    chk(q, 32'h0);
    cyc(OS + 20);
    rd(ADDR_DATA);
    chk(q, 32'h0);
    wr(ADDR_DATA, 32'h2222);
    rd(ADDR_DATA);
    chk(q, 32'h2222);
    want[2] <= 1'b1;
    cyc(5);
    wr(ADDR_CTRL, 32'h2);
    b = ngo;
    wr(ADDR_CS1, 32'h05);
    cyc(10);
    chk(32'(ngo - b), 32'h0);
    want[2] <= 1'b0;
    cyc(10);
    chk(32'(ngo - b), 32'h1);
    chk(32'(last_cmd), {23'h0, 3'h2, 6'h05});
    // Dual-port mode from here; let every hold lapse first.
    dual_port_sw <= 1'b1;
    cyc(3 * OS);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_CS1);
    chk(q & 32'h83F, 32'h0);
    rd(ADDR_STAT);
    chk(q & 32'h1FFFF, 32'h0);
    wr(ADDR_DATA, 32'h1234);
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h1);
    chk(32'(held), 32'h01);
    rd(ADDR_DATA);
    chk(q, 32'h2222);
    wr(ADDR_DATA, 32'hABCD);
    rd(ADDR_DATA);
    chk(q, 32'hABCD);
    rd(ADDR_CS1);
    chk(32'(q[11]), 32'h1);
    repeat (4)
    begin
      cyc(OS - 15);
      rd(ADDR_CS1);
    end
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h1);
    cyc(OS + 10);
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h0);
    wr(ADDR_DATA, 32'h0);
    b = ngo;
    wr(ADDR_CS1, 32'h05);
    cyc(4);
    chk(32'(ngo - b), 32'h1);
    chk(32'(last_cmd), {23'h0, 3'h0, 6'h05});
    wr(ADDR_CS1, {26'h0, FUNC_RELEASE});
    cyc(3);
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h0);
    // A transfer freezes timers and ownership.
    wr(ADDR_DATA, 32'h0);
    xfer_active <= 1'b1;
    cyc(2 * OS);
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h1);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_DATA, 32'h0);
    rd(ADDR_STAT);
    chk(32'(q[3]), 32'h0);
    xfer_active <= 1'b0;
    cyc(OS + 20);
    rd(ADDR_STAT);
    chk(q & 32'hFF, 32'h0);
    // Drive 1 is busy on the far port.
    want[1] <= 1'b1;
    cyc(5);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_DATA, 32'h5555);
    rd(ADDR_DATA);
    chk(q, 32'h0);
    rd(ADDR_CS1);
    chk(32'(q[11]), 32'h0);
    b = ngo;
    wr(ADDR_CS1, 32'h45);
    rd(ADDR_STAT);
    chk(32'(q[9]), 32'h1);
    chk(32'(q[16]), 32'h1);
    chk(32'(ngo - b), 32'h0);
    want[1] <= 1'b0;
    cyc(8);
    rd(ADDR_STAT);
    chk(32'(q[1]), 32'h1);
    rd(ADDR_DSTAT);
    chk(32'(q[15]), 32'h1);
    chk(32'(irq), 32'h1);
    // The host leaves the attention unanswered.
    cyc(OS + 10);
    rd(ADDR_STAT);
    chk(32'(q[1]), 32'h0);
    rd(ADDR_ATTN);
    chk(32'(q[1]), 32'h1);
    wr(ADDR_ATTN, 32'h2);
    cyc(3);
    rd(ADDR_STAT);
    chk(32'(q[1]), 32'h1);
    wr(ADDR_CTRL, 32'h21);
    rd(ADDR_STAT);
    chk(q & 32'h1FF00, 32'h0);
    // An unmapped word is refused and reads zero.
    rd(8'h1C);
    chk(q, 32'h0);
    chk(32'(lerr), 32'h1);
    // Second reset with dual access on: no stall, dual port still dominates.
    nrst <= 1'b0;
    dual_access_sw <= 1'b1;
    cyc(12);
    nrst <= 1'b1;
    cyc(6);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_DATA, 32'h77);
    cyc(3);
    rd(ADDR_STAT);
    chk(32'(q[0]), 32'h1);
    rd(ADDR_TYPE);
    chk(32'(q[11]), 32'h0);
    dual_port_sw <= 1'b0;
    cyc(5);
    rd(ADDR_TYPE);
    chk(32'(q[11]), 32'h1);
    rd(ADDR_DSTAT);
    chk(32'(q[9]), 32'h1);
    want[4] <= 1'b1;
    cyc(5);
    wr(ADDR_CTRL, 32'h4);
    b = ngo;
    wr(ADDR_CS1, 32'h05);
    cyc(5);
    chk(32'(ngo - b), 32'h0);
    want[4] <= 1'b0;
    cyc(10);
    chk(32'(ngo - b), 32'h1);
    chk(32'(last_cmd), {23'h0, 3'h4, 6'h05});
    results();
  end
endmodule : testbench

// >>> hdl/dual_port_seize.sv
`timescale 1ns/10ps
// Summary of operation
// - Host write or attention one requests seizure.
// - Held drive shows drive-available flag.
// - Other-held drive reads zero, ignores writes.
// - Busy-elsewhere request remembered until release.
// - Release command returns drive to unseized.
// - One-second timer releases unless seizing repeated.
// - Control read of held drive restarts timer.
// - Control read unheld: shared bits, no request.
// - Other registers read zero unless held.
// - Control write unheld: request, try go.
// - Control write held loads function; release frees.
// - Other write unheld: discarded, request set.
// - Other write held: update, restart timer.
// - Freed requested drive seized, attention raised.
// - Unanswered attention: release, attention stays set.
// - No neutral state; unheld means busy elsewhere.
// - Transfer running halts timers, seize, release.
// - Single-port: appears held, no attention, waits.
// - Dual access sets mode and programmable flags.
// - Dual access: free runs, busy waits.
// - First detection stalls drive one second.
// - Dual access bypasses stall; dual port dominates.
module dual_port_seize
  import seize_pkg::*;
#(
  parameter int NDRV = 8,
  parameter int ONE_SEC = ONE_SEC_CYCLES
)(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive side pins, asynchronous
  input wire logic [NDRV-1:0] other_busy,
  input wire logic [NDRV-1:0] drive_present,
  input wire logic dual_port_sw,
  input wire logic dual_access_sw,
  // Transfer engine, same clock
  input wire logic xfer_active,
  // Results
  output logic [NDRV-1:0] held,
  output logic cmd_go,
  output cmd_s cmd,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [NDRV-1:0] busy_s1_reg, busy_reg, pres_s1_reg, pres_reg;
  sw_s sw_s1_reg, sw_reg;

  // Pins are only read after the second stage.
  always_ff @(posedge clk)
  begin
    busy_s1_reg <= other_busy;
    busy_reg <= busy_s1_reg;
    pres_s1_reg <= drive_present;
    pres_reg <= pres_s1_reg;
    sw_s1_reg <= '{dual_port: dual_port_sw, dual_access: dual_access_sw};
    sw_reg <= sw_s1_reg;
  end

  wire dual_mode = sw_reg.dual_port;
  wire access_mode = sw_reg.dual_access & ~sw_reg.dual_port;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic [2:0] unit_reg;
  logic ie_reg, opi_reg;
  logic [NDRV-1:0] req_reg, ata_reg, pend_reg;
  logic [NDRV-1:0][5:0] func_reg;
  logic [NDRV-1:0][15:0] data_reg;
  logic [NDRV-1:0] held_w, touch_w, seize_w, attn_w, visible_w;

  // One wait state keeps every bus output on a flip-flop.
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_cs1 = paddr == ADDR_CS1;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_attn = paddr == ADDR_ATTN;
  wire hit_data = paddr == ADDR_DATA;
  wire hit_type = paddr == ADDR_TYPE;
  wire hit_dstat = paddr == ADDR_DSTAT;
  wire hit_stat = paddr == ADDR_STAT;
  wire mapped = hit_cs1 | hit_ctrl | hit_attn | hit_data | hit_type | hit_dstat | hit_stat;
  wire drive_reg = hit_cs1 | hit_data | hit_type | hit_dstat;
  wire clear = wr & hit_ctrl & pwdata[CTRL_CLEAR];
  wire unit_ok = 32'(unit_reg) < NDRV;
  wire sel_vis = unit_ok & visible_w[unit_reg];
  wire sel_busy = unit_ok & busy_reg[unit_reg];
  wire cs1_wr = wr & hit_cs1 & unit_ok;
  wire go_wr = cs1_wr & pwdata[CS1_GO];
  wire [5:0] wfunc = pwdata[5:0];
  wire [NDRV-1:0] pend_go = pend_reg & ~busy_reg;

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  logic [31:0] rdata;

  // Shared bits always readable; drive bits only while visible.
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (hit_cs1)
    begin
      rdata[CS1_IE] = ie_reg;
      if (sel_vis)
      begin
        rdata[CS1_DVA] = 1'b1;
        rdata[5:0] = func_reg[unit_reg];
      end
    end
    else if (hit_data && sel_vis)
      rdata[15:0] = data_reg[unit_reg];
    else if (hit_type && sel_vis)
      rdata[TYPE_DPM] = access_mode;
    else if (hit_dstat && sel_vis)
    begin
      rdata[DSTAT_PGM] = access_mode;
      rdata[DSTAT_ATA] = ata_reg[unit_reg];
    end
    else if (hit_ctrl)
      rdata[2:0] = unit_reg;
    else if (hit_attn)
      rdata[NDRV-1:0] = ata_reg;
    else if (hit_stat)
    begin
      rdata[NDRV-1:0] = held_w;
      rdata[STAT_REQ_LO +: NDRV] = req_reg;
      rdata[STAT_OPI] = opi_reg;
    end
  end

  // Bus answer registers.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      prdata <= rdata;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-drive ownership and timers
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NDRV; gi++)
    begin : g_drv
      drive_st_e st_reg, st_next;
      logic [TIMER_W-1:0] tmr_reg, tmr_next;
      wire me = unit_reg == 3'(gi);
      // any drive register write, or attention bit one
      wire touch = (wr & drive_reg & me) | (wr & hit_attn & pwdata[gi]);
      wire cs1_rd = rd & hit_cs1 & me;
      // release function on a held drive
      wire rel = cs1_wr & me & (st_reg == ST_HELD) & (wfunc == FUNC_RELEASE);
      // unheld is busy elsewhere; seize only once the far port lets go
      wire grab = (st_reg == ST_FREE) & (req_reg[gi] | touch) & ~busy_reg[gi];
      assign touch_w[gi] = touch;
      assign held_w[gi] = st_reg == ST_HELD;
      // nothing seized while a transfer runs
      assign seize_w[gi] = grab & ~xfer_active;
      // attention only for a pending request in dual-port mode
      assign attn_w[gi] = seize_w[gi] & req_reg[gi] & dual_mode;
      // outside dual-port mode the drive looks held unless it is stalled
      assign visible_w[gi] = (held_w[gi] | ~dual_mode) & (st_reg != ST_STALL);

      // Ownership state and shared one-second down counter.
      always_comb
      begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        case (st_reg)
          ST_ABSENT:
            // first detection stalls unless dual access set
            if (pres_reg[gi])
            begin
              st_next = sw_reg.dual_access ? ST_FREE : ST_STALL;
              tmr_next = TIMER_W'(ONE_SEC - 1);
            end
          ST_STALL:
            if (tmr_reg == '0)
              st_next = ST_FREE;
            else if (!xfer_active)
              tmr_next = tmr_reg - 1'b1;
          ST_FREE:
            if (seize_w[gi])
            begin
              st_next = ST_HELD;
              tmr_next = TIMER_W'(ONE_SEC - 1);
            end
          ST_HELD:
            if (!xfer_active)
            begin
              if (touch || cs1_rd)
                tmr_next = TIMER_W'(ONE_SEC - 1);
              else if (tmr_reg != '0)
                tmr_next = tmr_reg - 1'b1;
              // release; attention bit is left alone
              if (rel || (tmr_reg == '0 && !touch && !cs1_rd))
                st_next = ST_FREE;
            end
          default:
            st_next = ST_ABSENT;
        endcase
        if (clear)
          tmr_next = TIMER_W'(ONE_SEC - 1);
      end

      always_ff @(posedge clk)
      begin
        if (!nrst)
        begin
          st_reg <= ST_ABSENT;
          tmr_reg <= '0;
        end
        else
        begin
          st_reg <= st_next;
          tmr_reg <= tmr_next;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Request, attention, command and data registers
  // ---------------------------------------------------------------------------
  logic launch_pend;
  logic [2:0] pend_unit;

  // Lowest-numbered waiting drive wins; one command leaves per cycle.
  always_comb
  begin
    launch_pend = 1'b0;
    pend_unit = 3'h0;
    for (int k = NDRV - 1; k >= 0; k--)
      if (pend_go[k])
      begin
        launch_pend = 1'b1;
        pend_unit = 3'(k);
      end
  end

  // A direct go issues now when the drive is reachable and idle.
  wire go_now = go_wr & sel_vis & ~(sel_busy & ~dual_mode);
  // outside dual-port mode a busy drive holds the go.
  wire go_wait = go_wr & ~dual_mode & sel_busy;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      unit_reg <= 3'h0;
      ie_reg <= 1'b0;
      opi_reg <= 1'b0;
      req_reg <= '0;
      ata_reg <= '0;
      pend_reg <= '0;
      func_reg <= '0;
      data_reg <= {NDRV{DATA_RESET}};
      cmd_go <= 1'b0;
      cmd <= '0;
      irq <= 1'b0;
      held <= '0;
    end
    else
    begin
      if (wr && hit_ctrl)
        unit_reg <= pwdata[CTRL_UNIT_LO +: 3];
      if (wr && hit_cs1)
        ie_reg <= pwdata[CS1_IE];
      // go on an unheld drive fails as operation incomplete
      if (go_wr && dual_mode && !sel_vis)
        opi_reg <= 1'b1;
      else if (clear)
        opi_reg <= 1'b0;
      // remember touches on unheld drives; clear
      // A touch that seizes at once leaves no request to fire after a later release.
      if (clear)
        req_reg <= touch_w & ~held_w & ~seize_w;
      else
        req_reg <= (req_reg | (touch_w & ~held_w)) & ~seize_w;
      // set wins over a host clear by writing one
      ata_reg <= (ata_reg & ~((wr && hit_attn) ? pwdata[NDRV-1:0] : '0)) | attn_w;
      // function loads only when visible, or queued to wait
      if (cs1_wr && (sel_vis || go_wait))
        func_reg[unit_reg] <= wfunc;
      // data register updates only while visible
      if (wr && hit_data && sel_vis)
        data_reg[unit_reg] <= pwdata[15:0];
      if (go_now)
      begin
        cmd_go <= 1'b1;
        cmd <= '{unit: unit_reg, func: wfunc};
      end
      else if (launch_pend)
      begin
        cmd_go <= 1'b1;
        cmd <= '{unit: pend_unit, func: func_reg[pend_unit]};
      end
      else
        cmd_go <= 1'b0;
      for (int k = 0; k < NDRV; k++)
        if (go_wait && unit_reg == 3'(k))
          pend_reg[k] <= 1'b1;
        else if (!go_now && launch_pend && pend_unit == 3'(k))
          pend_reg[k] <= 1'b0;
      // interrupt on attention with enable set
      irq <= ie_reg & (|ata_reg);
      held <= held_w;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  seize_sets_held_a: assert property (seize_w[0] |=> held_w[0] ##1 held[0])
    else $error("Seized drive did not become held.");
  attn_on_pend_a: assert property (attn_w[0] |=> ata_reg[0])
    else $error("Attention not raised after pending seize.");
  no_attn_single_a: assert property (!dual_mode |-> attn_w == '0)
    else $error("Attention raised outside dual-port mode.");
  xfer_freeze_a: assert property (xfer_active |-> seize_w == '0)
    else $error("Drive seized during a transfer.");
  xfer_timer_a: assert property (xfer_active && !clear && g_drv[0].st_reg == ST_HELD
    |=> $stable(g_drv[0].tmr_reg))
    else $error("Timer moved during a transfer.");
  read_restart_a: assert property (g_drv[0].cs1_rd && held_w[0] && !xfer_active
    |=> g_drv[0].tmr_reg == TIMER_W'(ONE_SEC - 1))
    else $error("Control read did not restart timer.");
  expiry_frees_a: assert property (held_w[0] && g_drv[0].tmr_reg == '0 && !xfer_active
    && !touch_w[0] && !g_drv[0].cs1_rd |=> !held_w[0] && $stable(ata_reg[0]))
    else $error("Expired drive not released or attention lost.");
  hidden_zero_a: assert property (rd && hit_data && !sel_vis |=> prdata == 32'h0000_0000)
    else $error("Hidden drive register read nonzero.");
  unheld_req_a: assert property (dual_mode && touch_w[0] && !held_w[0] |=> req_reg[0]
    || held_w[0])
    else $error("Write on unheld drive did not request.");
  stall_block_a: assert property (g_drv[0].st_reg == ST_STALL |-> !visible_w[0])
    else $error("Stalled drive was accessible.");
  release_cmd_a: assert property (g_drv[0].rel && !xfer_active |=> !held_w[0])
    else $error("Release command left drive held.");

  seize_pend_c: cover property (attn_w[0]);
  timeout_c: cover property (held_w[0] ##1 !held_w[0]);
  wait_go_c: cover property (go_wait ##[1:20] cmd_go);

endmodule : dual_port_seize

// >>> hdl/seize_pkg.sv
package seize_pkg;

  // ---------------------------------------------------------------------------
  // Register map, byte addresses on the APB bus
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CS1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_ATTN = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_TYPE = 8'h10;
  localparam logic [7:0] ADDR_DSTAT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CS1_GO = 0;
  localparam int CS1_FUNC_LO = 1;
  localparam int CS1_IE = 6;
  localparam int CS1_DVA = 11;
  localparam int CTRL_UNIT_LO = 0;
  localparam int CTRL_CLEAR = 5;
  localparam int TYPE_DPM = 11;
  localparam int DSTAT_PGM = 9;
  localparam int DSTAT_ATA = 15;
  localparam int STAT_REQ_LO = 8;
  localparam int STAT_OPI = 16;

  // Function code including the go bit; release is octal 13.
  localparam logic [5:0] FUNC_RELEASE = 6'h0B;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam longint ONE_SEC_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 50;
  localparam int ONE_SEC_CYCLES = int'(ONE_SEC_NS / CLK_PERIOD_NS);
  localparam int TIMER_W = 25;

  // Per-drive ownership state.
  typedef enum logic [1:0] {ST_ABSENT, ST_STALL, ST_FREE, ST_HELD} drive_st_e;

  // Command handed to the drive sequencer.
  typedef struct packed {
    logic [2:0] unit;
    logic [5:0] func;
  } cmd_s;

  // Option switches after synchronisation.
  typedef struct packed {
    logic dual_port;
    logic dual_access;
  } sw_s;

endpackage : seize_pkg
